/* File: qdsl_serial_load.sv */
/*
 qdsl_serial_load: serial shift register, per-channel input and converter
 registers, load strobe, clear and coding for a quad converter.
 assumes: all pins are asynchronous to core_clk; serial clock well below
 a quarter of core_clk so each level is seen at least twice.
*/
`timescale 1ns/10ps
// the guard lets the package and the design both pull the constants in
`include "qdsl_cfg.svh"

module qdsl_serial_load
    import qdsl_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int NUM_CH = 4
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic core_en,
    // serial link
    input wire logic frame_sel_n,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    output logic serial_data_out,
    // control pins
    input wire logic load_outputs_n,
    input wire logic async_clear_n,
    input wire logic bipolar_coding_select,
    // converter side, straight binary codes
    output logic [NUM_CH-1:0][DATA_W-1:0] dac_code,
    output logic [NUM_CH-1:0] dac_bipolar
);
    localparam int PW = $bits(qdsl_pins_s);
    localparam int FW = $bits(qdsl_cmd_s);
    localparam int CW = `QDSL_CMD_DATA_W;
    localparam logic [DATA_W-1:0] MSB_MASK = {1'b1, {(DATA_W-1){1'b0}}};

    if (!(DATA_W == 12 || DATA_W == 14 || DATA_W == 16) || NUM_CH < 1 || NUM_CH > 4) begin : g_bad
        $error("qdsl_serial_load: DATA_W must be 12/14/16 and NUM_CH 1..4");
    end

    // two-stage synchronisers, first stage read by nothing else
    logic [PW-1:0] pin_raw;
    logic [PW-1:0] pin_meta_q;
    logic [PW-1:0] pin_sync_q;
    qdsl_pins_s cur;
    qdsl_pins_s prev_q;
    assign pin_raw = {frame_sel_n, serial_clk, serial_data_in, load_outputs_n,
                      async_clear_n, bipolar_coding_select};
    assign cur = qdsl_pins_s'(pin_sync_q);

    for (genvar i = 0; i < PW; i++) begin : g_sync
        localparam logic [PW-1:0] RST = `QDSL_PINS_RST;
        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                pin_meta_q[i] <= RST[i];
                pin_sync_q[i] <= RST[i];
            end else if (core_en) begin
                pin_meta_q[i] <= pin_raw[i];
                pin_sync_q[i] <= pin_meta_q[i];
            end
        end
    end

    logic sclk_fall;
    logic sclk_rise;
    logic frame_rise;
    logic load_outputs_n_fall;
    assign sclk_fall = prev_q.sclk & ~cur.sclk;
    assign sclk_rise = ~prev_q.sclk & cur.sclk;
    assign frame_rise = ~prev_q.frame_n & cur.frame_n;
    assign load_outputs_n_fall = prev_q.load_outputs_n_n & ~cur.load_outputs_n_n;

    // state
    qdsl_st_e st_q, st_d;
    logic [FW-1:0] shreg_q, shreg_d;
    logic [4:0] cnt_q, cnt_d;
    logic sdo_q, sdo_d;
    logic [NUM_CH-1:0][DATA_W-1:0] in_q, in_d;
    logic [NUM_CH-1:0][DATA_W-1:0] conv_q, conv_d;
    logic [NUM_CH-1:0][DATA_W-1:0] code_q, code_d;
    logic [NUM_CH-1:0][DATA_W-1:0] clr_raw;
    logic [NUM_CH-1:0] pend_q, pend_d;
    logic [NUM_CH-1:0] uni_q, uni_d;
    logic [NUM_CH-1:0] flip;
    logic clrsel_q, clrsel_d;
    // range flag kept in its own flop so the output pin has no gate after it
    logic [NUM_CH-1:0] bip_q, bip_d;
    qdsl_cmd_s cmd;
    logic cmd_ok;
    assign cmd = qdsl_cmd_s'(shreg_q);
    assign cmd_ok = (cnt_q == `QDSL_FRAME_BITS);
    assign bip_d = ~uni_d;

    for (genvar c = 0; c < NUM_CH; c++) begin : g_code
        // twos complement is turned into straight binary by the msb flip
        assign flip[c] = ~uni_q[c] & ~cur.coding;
        // clear target is expressed in output coding, so undo the flip
        assign clr_raw[c] = (clrsel_q ? MSB_MASK : '0) ^ (flip[c] ? MSB_MASK : '0);
    end

    always_comb begin
        logic [CW-1:0] rb;
        rb = '0;
        st_d = st_q;
        shreg_d = shreg_q;
        cnt_d = cnt_q;
        sdo_d = sdo_q;
        in_d = in_q;
        conv_d = conv_q;
        pend_d = pend_q;
        uni_d = uni_q;
        clrsel_d = clrsel_q;
        // strobe first: a write in the same cycle sees the load already low
        if (load_outputs_n_fall) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (pend_q[c]) begin
                    conv_d[c] = in_q[c];
                end
            end
            pend_d = '0;
        end
        unique case (st_q)
            QDSL_IDLE: begin
                if (!cur.frame_n) begin
                    st_d = QDSL_SHIFT;
                    cnt_d = '0;
                    // the first bit must stand before the first falling clock
                    sdo_d = shreg_q[FW-1];
                end
            end
            QDSL_SHIFT: begin
                if (sclk_fall && !cur.frame_n) begin
                    shreg_d = {shreg_q[FW-2:0], cur.sdi};
                    if (cnt_q != 5'h1f) begin
                        cnt_d = cnt_q + 5'h01;
                    end
                end
                if (sclk_rise && !cur.frame_n) begin
                    sdo_d = shreg_q[FW-1];
                end
                if (frame_rise) begin
                    st_d = QDSL_IDLE;
                    // frames of the wrong length are dropped whole
                    if (cmd_ok && cmd.rd) begin
                        for (int c = 0; c < NUM_CH; c++) begin
                            if (cmd.addr == 3'(c)) begin
                                unique case (cmd.sel)
                                    QDSL_DAC: rb[CW-1 -: DATA_W] = in_q[c];
                                    QDSL_RANGE: rb[`QDSL_RANGE_BIP_BIT] = ~uni_q[c];
                                    QDSL_CTRL: rb[`QDSL_CLRSEL_BIT] = clrsel_q;
                                    default: rb = '0;
                                endcase
                            end
                        end
                        // readback word leaves on the next frame
                        shreg_d = {1'b0, 1'b0, cmd.sel, cmd.addr, rb};
                    end else if (cmd_ok) begin
                        for (int c = 0; c < NUM_CH; c++) begin
                            if (cmd.addr == 3'(c) || cmd.addr == `QDSL_ALL_CH) begin
                                unique case (cmd.sel)
                                    QDSL_DAC: begin
                                        in_d[c] = cmd.data[CW-1 -: DATA_W];
                                        if (!cur.load_outputs_n_n) begin
                                            conv_d[c] = cmd.data[CW-1 -: DATA_W];
                                            pend_d[c] = 1'b0;
                                        end else begin
                                            pend_d[c] = 1'b1;
                                        end
                                    end
                                    QDSL_RANGE: uni_d[c] = ~cmd.data[`QDSL_RANGE_BIP_BIT];
                                    QDSL_CTRL: clrsel_d = cmd.data[`QDSL_CLRSEL_BIT];
                                    default: uni_d[c] = uni_q[c];
                                endcase
                            end
                        end
                    end
                end
            end
        endcase
        // clear wins over every load while held
        if (!cur.clr_n) begin
            conv_d = clr_raw;
        end
    end

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            code_d[c] = conv_q[c] ^ (flip[c] ? MSB_MASK : '0);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= qdsl_pins_s'(`QDSL_PINS_RST);
            st_q <= QDSL_IDLE;
            shreg_q <= '0;
            cnt_q <= '0;
            sdo_q <= 1'b0;
            in_q <= '0;
            conv_q <= '0;
            code_q <= '0;
            pend_q <= '0;
            uni_q <= {NUM_CH{`QDSL_UNI_RST}};
            bip_q <= {NUM_CH{~`QDSL_UNI_RST}};
            clrsel_q <= `QDSL_CLRSEL_RST;
        end else if (core_en) begin
            prev_q <= cur;
            st_q <= st_d;
            shreg_q <= shreg_d;
            cnt_q <= cnt_d;
            sdo_q <= sdo_d;
            in_q <= in_d;
            conv_q <= conv_d;
            code_q <= code_d;
            pend_q <= pend_d;
            uni_q <= uni_d;
            bip_q <= bip_d;
            clrsel_q <= clrsel_d;
        end
    end

    assign serial_data_out = sdo_q;
    assign dac_code = code_q;
    assign dac_bipolar = bip_q;

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    logic wr0;
    assign wr0 = st_q == QDSL_SHIFT && frame_rise && cmd_ok && !cmd.rd && cmd.sel == QDSL_DAC
        && (cmd.addr == 3'h0 || cmd.addr == `QDSL_ALL_CH) && cur.clr_n && core_en;

    property p_shift;
        st_q == QDSL_SHIFT && sclk_fall && !cur.frame_n && core_en
            |=> shreg_q[0] == $past(cur.sdi);
    endproperty
    a_shift: assert property (p_shift) else $error("bit not shifted");

    property p_idle_hold;
        st_q == QDSL_IDLE && cur.frame_n && core_en |=> shreg_q == $past(shreg_q);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("shift outside frame");

    property p_direct;
        wr0 && !cur.load_outputs_n_n |=> conv_q[0] == $past(cmd.data[CW-1 -: DATA_W]) && !pend_q[0];
    endproperty
    a_direct: assert property (p_direct) else $error("direct load missed");

    property p_defer;
        wr0 && cur.load_outputs_n_n && !load_outputs_n_fall
            |=> pend_q[0] && conv_q[0] == $past(conv_q[0]) && in_q[0] == $past(cmd.data[CW-1 -: DATA_W]);
    endproperty
    a_defer: assert property (p_defer) else $error("deferred load wrong");

    property p_load_outputs_n;
        load_outputs_n_fall && pend_q[0] && cur.clr_n && !frame_rise && core_en
            |=> conv_q[0] == $past(in_q[0]) && !pend_q[0];
    endproperty
    a_load_outputs_n: assert property (p_load_outputs_n) else $error("strobe copy missed");

    property p_clear;
        !cur.clr_n && core_en |=> conv_q[0] == $past(clr_raw[0]);
    endproperty
    a_clear: assert property (p_clear) else $error("clear not applied");

    property p_clear_out;
        (!cur.clr_n && core_en)[*2] ##1 core_en
            |-> dac_code[0] == ($past(clrsel_q, 2) ? MSB_MASK : '0);
    endproperty
    a_clear_out: assert property (p_clear_out) else $error("clear scale wrong");

    property p_twos;
        core_en && !uni_q[0] && !cur.coding |=> dac_code[0][DATA_W-1] != $past(conv_q[0][DATA_W-1]);
    endproperty
    a_twos: assert property (p_twos) else $error("twos coding wrong");

    property p_uni;
        core_en && (uni_q[0] || cur.coding) |=> dac_code[0] == $past(conv_q[0]);
    endproperty
    a_uni: assert property (p_uni) else $error("straight coding wrong");

    property p_sdo;
        st_q == QDSL_SHIFT && sclk_rise && !cur.frame_n && core_en
            |=> serial_data_out == $past(shreg_q[FW-1]);
    endproperty
    a_sdo: assert property (p_sdo) else $error("serial out wrong");

    property p_sdo_first;
        st_q == QDSL_IDLE && !cur.frame_n && core_en
            |=> serial_data_out == $past(shreg_q[FW-1]);
    endproperty
    a_sdo_first: assert property (p_sdo_first) else $error("first out bit missing");

    // a cut or overlong frame must leave every stored setting alone
    property p_short;
        st_q == QDSL_SHIFT && frame_rise && !cmd_ok && core_en
            |=> in_q == $past(in_q) && uni_q == $past(uni_q) && clrsel_q == $past(clrsel_q);
    endproperty
    a_short: assert property (p_short) else $error("bad frame length acted on");

    c_direct: cover property (wr0 && !cur.load_outputs_n_n);
    c_defer: cover property (wr0 && cur.load_outputs_n_n ##[1:1000] load_outputs_n_fall);
    c_clear: cover property (!cur.clr_n && clrsel_q);
    c_read: cover property (st_q == QDSL_SHIFT && frame_rise && cmd_ok && cmd.rd);
endmodule

/* File: qdsl_cfg.svh */
// Operation
// - bipolar: coding pin high offset, low twos
// - unipolar ranges always straight binary
// - bits accepted only while frame select low
// - falling serial clock shifts input bit in
// - frame select rising completes the command
// - load low: converter updates at frame end
// - load high: input only, output waits
// - load falling copies all pending channels
// - clear forces zero or mid scale
// - output shifts on rising, host samples falling
/*
 qdsl_cfg.svh: constants of the quad converter serial load front end.
 assumes: included by bare name, by the package and by the design; guarded.
*/
`ifndef QDSL_CFG_SVH
`define QDSL_CFG_SVH

`define QDSL_FRAME_BITS 5'h18
`define QDSL_CMD_DATA_W 16
`define QDSL_ALL_CH 3'h4
`define QDSL_SEL_DAC 3'h0
`define QDSL_SEL_RANGE 3'h1
`define QDSL_SEL_CTRL 3'h3
`define QDSL_RANGE_BIP_BIT 0
`define QDSL_CLRSEL_BIT 0
`define QDSL_CLRSEL_RST 1'h0
`define QDSL_UNI_RST 1'h1
`define QDSL_PINS_RST 6'h36

`endif

/* File: qdsl_pkg.sv */
/*
 qdsl_pkg: types of the quad converter serial load front end.
 assumes: qdsl_cfg.svh is on the include path.
*/
package qdsl_pkg;
`include "qdsl_cfg.svh"

    typedef enum logic [2:0] {
        QDSL_DAC = `QDSL_SEL_DAC,
        QDSL_RANGE = `QDSL_SEL_RANGE,
        QDSL_CTRL = `QDSL_SEL_CTRL
    } qdsl_sel_e;

    typedef enum logic {
        QDSL_IDLE = 1'b0,
        QDSL_SHIFT = 1'b1
    } qdsl_st_e;

    // one 24-bit frame, first bit shifted in is rd
    typedef struct packed {
        logic rd;
        logic spare;
        qdsl_sel_e sel;
        logic [2:0] addr;
        logic [`QDSL_CMD_DATA_W-1:0] data;
    } qdsl_cmd_s;

    typedef struct packed {
        logic frame_n;
        logic sclk;
        logic sdi;
        logic load_outputs_n_n;
        logic clr_n;
        logic coding;
    } qdsl_pins_s;
endpackage

/* File: qdsl_host_model.sv */
/*
 qdsl_host_model: serial host that drives frames into the converter front end.
 assumes: core_clk runs at 125 MHz; the link clock has a 64 ns period.
*/
`timescale 1ns/10ps
module qdsl_host_model (
    // clock
    input wire logic core_clk,
    // serial link
    output logic frame_sel_n,
    output logic serial_clk,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    logic [23:0] rx_bits;

    initial begin
        frame_sel_n = 1'b1;
        serial_clk = 1'b1;
        serial_data_in = 1'b0;
        rx_bits = 24'h00_0000;
    end

    // half a link period is four core cycles
    task automatic half_wait();
        repeat (4) @(negedge core_clk);
    endtask

    task automatic send_frame(input logic [23:0] word, input int nbits);
        frame_sel_n = 1'b0;
        half_wait();
        for (int i = nbits - 1; i >= 0; i--) begin
            serial_data_in = word[i];
            half_wait();
            // the host reads the output bit at the falling clock
            rx_bits = {rx_bits[22:0], serial_data_out};
            serial_clk = 1'b0;
            half_wait();
            serial_clk = 1'b1;
        end
        half_wait();
        frame_sel_n = 1'b1;
        // released line must not keep showing the last bit
        serial_data_in = ~serial_data_in;
        // long gap covers the readback frame spacing
        repeat (24) @(negedge core_clk);
    endtask
endmodule

/* File: tb_qdsl_serial_load.sv */
/*
 tb_qdsl_serial_load: self-checking bench for the quad converter serial front end.
 assumes: qdsl_pkg and qdsl_host_model are compiled first.
*/
`timescale 1ns/10ps
module tb_qdsl_serial_load import qdsl_pkg::*;;
    logic core_clk, rst_b, core_en, frame_sel_n, serial_clk, serial_data_in;
    logic serial_data_out, load_outputs_n, async_clear_n, bipolar_coding_select;
    logic [3:0][15:0] dac_code;
    logic [3:0] dac_bipolar;
    logic [15:0] val;
    logic [15:0] ch_val [4];
    int bad_count, compares, cycles, seed;

    qdsl_serial_load u_qdsl_serial_load (.core_clk(core_clk), .rst_b(rst_b),
        .core_en(core_en), .frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .load_outputs_n(load_outputs_n), .async_clear_n(async_clear_n),
        .bipolar_coding_select(bipolar_coding_select), .dac_code(dac_code),
        .dac_bipolar(dac_bipolar));
    qdsl_host_model u_qdsl_host_model (.core_clk(core_clk), .frame_sel_n(frame_sel_n),
        .serial_clk(serial_clk), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    function automatic logic [23:0] mk(logic rd, qdsl_sel_e sel, logic [2:0] a, logic [15:0] d);
        qdsl_cmd_s c;
        c = '{rd: rd, spare: 1'b0, sel: sel, addr: a, data: d};
        return c;
    endfunction

    // twos complement becomes straight binary by flipping the top bit
    function automatic logic [15:0] exp_code(logic [15:0] d, logic bip, logic coding);
        return (bip && !coding) ? {~d[15], d[14:0]} : d;
    endfunction

    task automatic chk_code(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bits(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic [23:0] word, input int nbits);
        u_qdsl_host_model.send_frame(word, nbits);
        repeat (4) @(negedge core_clk);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard: the whole sequence needs about 3700 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    initial begin
        seed = 32'hd6e9;
        rst_b = 1'b0;
        core_en = 1'b1;
        load_outputs_n = 1'b0;
        async_clear_n = 1'b1;
        bipolar_coding_select = 1'b1;
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge core_clk);
        chk_bits({20'h0_0000, dac_bipolar}, 24'h00_0000);
        chk_bits({23'h00_0000, serial_data_out}, 24'h00_0000);
        for (int c = 0; c < 4; c++) begin
            chk_code(dac_code[c], 16'h0000);
            val = 16'($random(seed));
            ch_val[c] = val;
            xfer(mk(1'b0, QDSL_DAC, 3'(c), val), 24);
            chk_code(dac_code[c], val);
        end
        // a frame one bit short must be dropped whole
        xfer(mk(1'b0, QDSL_DAC, 3'h0, ~ch_val[0]), 23);
        chk_code(dac_code[0], ch_val[0]);
        load_outputs_n = 1'b1;
        val = 16'($random(seed));
        xfer(mk(1'b0, QDSL_DAC, 3'h4, val), 24);
        for (int c = 0; c < 4; c++) chk_code(dac_code[c], ch_val[c]);
        load_outputs_n = 1'b0;
        repeat (8) @(negedge core_clk);
        for (int c = 0; c < 4; c++) chk_code(dac_code[c], val);
        xfer(mk(1'b0, QDSL_RANGE, 3'h1, 16'h0001), 24);
        chk_bits({20'h0_0000, dac_bipolar}, 24'h00_0002);
        for (int k = 1; k >= 0; k--) begin
            bipolar_coding_select = k[0];
            val = 16'($random(seed));
            xfer(mk(1'b0, QDSL_DAC, 3'h1, val), 24);
            xfer(mk(1'b0, QDSL_DAC, 3'h0, val), 24);
            chk_code(dac_code[1], exp_code(val, 1'b1, k[0]));
            chk_code(dac_code[0], exp_code(val, 1'b0, k[0]));
        end
        // clock enable low freezes even the pin synchronisers, so clear is unseen
        core_en = 1'b0;
        async_clear_n = 1'b0;
        repeat (8) @(negedge core_clk);
        chk_code(dac_code[0], val);
        async_clear_n = 1'b1;
        repeat (4) @(negedge core_clk);
        core_en = 1'b1;
        repeat (4) @(negedge core_clk);
        chk_code(dac_code[0], val);
        for (int m = 0; m < 2; m++) begin
            xfer(mk(1'b0, QDSL_CTRL, 3'h0, 16'(m)), 24);
            async_clear_n = 1'b0;
            repeat (8) @(negedge core_clk);
            for (int c = 0; c < 4; c++) begin
                chk_code(dac_code[c], (m == 1) ? 16'h8000 : 16'h0000);
            end
            async_clear_n = 1'b1;
            repeat (4) @(negedge core_clk);
        end
        val = 16'($random(seed));
        xfer(mk(1'b0, QDSL_DAC, 3'h2, val), 24);
        xfer(mk(1'b1, QDSL_DAC, 3'h2, 16'h0000), 24);
        // unused select code leaves every register alone while the answer leaves
        xfer(24'h10_0000, 24);
        chk_bits(u_qdsl_host_model.rx_bits, {2'b00, QDSL_DAC, 3'h2, val});
        finish_test();
    end
endmodule
